// File: verilog/mpt_pwm_timer.sv
// PWM timer/counter with prescaler, seven match registers and AHB-Lite registers
`timescale 1ns/100ps
`include "mpt_regs.svh"

module mpt_pwm_timer #(
   parameter int CW = 32
) (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [1:0] cap_in,
   output logic [`MPT_NUM_OUT-1:0] pwm_out,
   output logic irq_out
);

   localparam int NM = `MPT_NUM_MR;
   localparam int NO = `MPT_NUM_OUT;

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   logic [CW-1:0] tc;
   logic [CW-1:0] pc;
   logic [CW-1:0] plim;
   logic [CW-1:0] mr_sh [NM];
   logic [CW-1:0] mr_act [NM];
   mpt_pkg::mpt_mact_type mctl [NM];
   logic [NM-1:0] stat;
   logic [NM-1:0] mask;
   logic [NM-1:0] ler;
   logic [NM-1:0] hit;
   logic [NO-1:0] dbl;
   logic [NO-1:0] oen;
   logic [2:0] csrc;
   logic en;
   logic crst;
   logic pwm_mode;
   logic cap_prev;
   logic cap_sel;
   logic ev;
   logic run;
   logic tick;
   logic rst_hit;
   logic stop_hit;
   logic [NM-1:0] irq_hit;
   mpt_pkg::mpt_dphase_type dp;
   logic rd_done;
   logic rd_cyc;
   logic wr;
   logic [31:0] rd_word;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic mr_addr(input logic [7:0] a, input int i);
      return a == (`MPT_OFF_MR0 + 8'(4 * i));
   endfunction

   function automatic logic [31:0] widen(input logic [CW-1:0] v);
      return 32'(v);
   endfunction

   // ---------------------------------------------
   // AHB-Lite slave
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         dp <= '0;
      end else if (hready_in) begin
         dp <= '{valid: hsel_in && htrans_in[1], write: hwrite_in, addr: haddr_in[7:0]};
      end
   end

   assign rd_cyc = dp.valid && !dp.write && !rd_done;
   assign wr = dp.valid && dp.write;
   assign hreadyout_out = !rd_cyc;
   assign hresp_out = 1'b0;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         rd_done <= 1'b0;
      end else begin
         rd_done <= rd_cyc;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         hrdata_out <= `MPT_RST_WORD;
      end else if (rd_cyc) begin
         hrdata_out <= rd_word;
      end
   end

   always_comb begin
      rd_word = `MPT_RST_WORD;
      case (dp.addr)
         `MPT_OFF_STAT: rd_word = 32'(stat);
         `MPT_OFF_CTRL: rd_word = 32'({pwm_mode, 1'b0, crst, en});
         `MPT_OFF_COUNT: rd_word = widen(tc);
         `MPT_OFF_PLIM: rd_word = widen(plim);
         `MPT_OFF_PCNT: rd_word = widen(pc);
         `MPT_OFF_MCTL: begin
            for (int i = 0; i < NM; i++) begin
               rd_word[3*i +: 3] = mctl[i];
            end
         end
         `MPT_OFF_CSRC: rd_word = 32'(csrc);
         `MPT_OFF_OCFG: rd_word = 32'({oen, 2'b00, dbl});
         `MPT_OFF_LATCH: rd_word = 32'(ler);
         `MPT_OFF_MASK: rd_word = 32'(mask);
         default: begin
            for (int i = 0; i < NM; i++) begin
               if (mr_addr(dp.addr, i)) begin
                  rd_word = widen(mr_sh[i]);
               end
            end
         end
      endcase
   end

   // ---------------------------------------------
   // Configuration registers
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         en <= 1'b0;
         crst <= 1'b0;
         pwm_mode <= 1'b0;
      end else if (wr && dp.addr == `MPT_OFF_CTRL) begin
         en <= hwdata_in[`MPT_CTRL_EN];
         crst <= hwdata_in[`MPT_CTRL_RST];
         pwm_mode <= hwdata_in[`MPT_CTRL_PWM];
      end else if (stop_hit) begin
         en <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         plim <= '0;
         csrc <= '0;
         dbl <= '0;
         oen <= '0;
         mask <= '0;
         for (int i = 0; i < NM; i++) begin
            mctl[i] <= '0;
         end
      end else if (wr) begin
         case (dp.addr)
            `MPT_OFF_PLIM: plim <= hwdata_in[CW-1:0];
            `MPT_OFF_CSRC: csrc <= hwdata_in[2:0];
            `MPT_OFF_OCFG: begin
               dbl <= hwdata_in[NO-1:0];
               oen <= hwdata_in[`MPT_OCFG_EN_LSB +: NO];
            end
            `MPT_OFF_MASK: mask <= hwdata_in[NM-1:0];
            `MPT_OFF_MCTL: begin
               for (int i = 0; i < NM; i++) begin
                  mctl[i] <= hwdata_in[3*i +: 3];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------
   // Count source and prescaler
   // ---------------------------------------------
   assign cap_sel = cap_in[csrc[`MPT_CSRC_SEL]];

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         cap_prev <= 1'b0;
      end else begin
         cap_prev <= cap_sel;
      end
   end

   always_comb begin
      unique case (mpt_pkg::mpt_src_type'(csrc[1:0]))
         mpt_pkg::MPT_SRC_TIMER: ev = 1'b1;
         mpt_pkg::MPT_SRC_RISE: ev = cap_sel && !cap_prev;
         mpt_pkg::MPT_SRC_FALL: ev = !cap_sel && cap_prev;
         mpt_pkg::MPT_SRC_BOTH: ev = cap_sel ^ cap_prev;
      endcase
   end

   assign run = en && !crst;
   assign tick = run && ev && pc == plim;

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || crst) begin
         pc <= '0;
      end else if (run && ev) begin
         pc <= (pc == plim) ? '0 : pc + 1'b1;
      end
   end

   // ---------------------------------------------
   // Match logic and counter
   // ---------------------------------------------
   always_comb begin
      rst_hit = 1'b0;
      stop_hit = 1'b0;
      for (int i = 0; i < NM; i++) begin
         hit[i] = tick && tc == mr_act[i];
         irq_hit[i] = hit[i] && mctl[i].irq;
         rst_hit = rst_hit | (hit[i] && mctl[i].rst);
         stop_hit = stop_hit | (hit[i] && mctl[i].stop);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in || crst) begin
         tc <= '0;
      end else if (tick) begin
         tc <= rst_hit ? '0 : tc + 1'b1;
      end
   end

   // ---------------------------------------------
   // Match registers with release
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < NM; i++) begin
            mr_sh[i] <= '0;
            mr_act[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NM; i++) begin
            if (wr && mr_addr(dp.addr, i)) begin
               mr_sh[i] <= hwdata_in[CW-1:0];
               if (!pwm_mode) begin
                  mr_act[i] <= hwdata_in[CW-1:0];
               end
            end
            if (pwm_mode && hit[0] && ler[i]) begin
               mr_act[i] <= mr_sh[i];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         ler <= '0;
      end else begin
         ler <= (ler & ~((pwm_mode && hit[0]) ? ler : '0))
               | ((wr && dp.addr == `MPT_OFF_LATCH) ? hwdata_in[NM-1:0] : '0);
      end
   end

   // ---------------------------------------------
   // Pulse outputs
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         pwm_out <= '0;
      end else begin
         for (int j = 0; j < NO; j++) begin
            if (!pwm_mode || !oen[j]) begin
               pwm_out[j] <= 1'b0;
            end else if (hit[j + 1]) begin
               pwm_out[j] <= 1'b0;
            end else if (dbl[j] ? hit[j] : hit[0]) begin
               pwm_out[j] <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------
   // Interrupts
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!resetn_in) begin
         stat <= '0;
      end else begin
         stat <= (stat & ~((wr && dp.addr == `MPT_OFF_STAT) ? hwdata_in[NM-1:0] : '0)) | irq_hit;
      end
   end

   assign irq_out = |(stat & mask);

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_mr1_write;
      wr && mr_addr(dp.addr, 1) && !pwm_mode;
   endsequence

   sequence s_mr1_direct;
      mr_act[1] == $past(hwdata_in[CW-1:0]);
   endsequence

   a_presc_wrap: assert property (run && ev && !crst && pc == plim |=> pc == '0 && tc != $past(tc))
      else $error("prescaler limit did not wrap or advance counter");
   a_match_reset: assert property (tick && rst_hit |=> tc == '0)
      else $error("reset match did not clear counter");
   a_match_stop: assert property (stop_hit && !(wr && dp.addr == `MPT_OFF_CTRL) |=> !en ##1 $stable(tc))
      else $error("stop match did not halt counter");
   a_match_irq: assert property (irq_hit[0] |=> stat[0])
      else $error("match interrupt flag not set");
   a_edge_single: assert property (pwm_mode && oen[0] && !dbl[0] && hit[0] && !hit[1] |=> pwm_out[0])
      else $error("single-edge output not raised at cycle start");
   a_edge_fall: assert property (hit[2] |=> !pwm_out[1])
      else $error("output not lowered at its match");
   a_edge_double: assert property (pwm_mode && oen[2] && dbl[2] && hit[2] && !hit[3] |=> pwm_out[2])
      else $error("double-edge output not raised by its rise match");
   a_shadow_hold: assert property (pwm_mode && !hit[0] && $stable(pwm_mode) |=> $stable(mr_act[1]))
      else $error("match value applied without release at cycle start");
   a_timer_direct: assert property (s_mr1_write |=> s_mr1_direct)
      else $error("timer mode match write not applied");
   a_count_event: assert property (!ev && !crst |=> $stable(tc) && $stable(pc))
      else $error("counter moved without a count event");

endmodule

// File: verilog/mpt_regs.svh
// Register offsets, field positions, reset values and counts of the PWM timer
`ifndef MPT_REGS_SVH
`define MPT_REGS_SVH

// ---------------------------------------------
// Byte offsets
// ---------------------------------------------
`define MPT_OFF_STAT 8'h00
`define MPT_OFF_CTRL 8'h04
`define MPT_OFF_COUNT 8'h08
`define MPT_OFF_PLIM 8'h0c
`define MPT_OFF_PCNT 8'h10
`define MPT_OFF_MCTL 8'h14
`define MPT_OFF_CSRC 8'h18
`define MPT_OFF_OCFG 8'h1c
`define MPT_OFF_LATCH 8'h20
`define MPT_OFF_MASK 8'h24
`define MPT_OFF_MR0 8'h28

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define MPT_CTRL_EN 0
`define MPT_CTRL_RST 1
`define MPT_CTRL_PWM 3
`define MPT_MCTL_IRQ 0
`define MPT_MCTL_RST 1
`define MPT_MCTL_STOP 2
`define MPT_CSRC_SEL 2
`define MPT_OCFG_EN_LSB 8

// ---------------------------------------------
// Counts and reset values
// ---------------------------------------------
`define MPT_NUM_MR 7
`define MPT_NUM_OUT 6
`define MPT_RST_WORD 32'h0000_0000

`endif

// File: verilog/mpt_pkg.sv
// Types shared by the PWM timer
package mpt_pkg;

   // Count clock source
   typedef enum logic [1:0] {
      MPT_SRC_TIMER,
      MPT_SRC_RISE,
      MPT_SRC_FALL,
      MPT_SRC_BOTH
   } mpt_src_type;

   // Latched bus address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } mpt_dphase_type;

   // Per-match action
   typedef struct packed {
      logic stop;
      logic rst;
      logic irq;
   } mpt_mact_type;

endpackage

// File: dv/mpt_load_model.sv
// Load model that measures pulse widths and periods of the outputs
`timescale 1ns/100ps
module mpt_load_model (
   input wire logic sys_clk_in,
   input wire logic resetn_in,
   input wire logic [5:0] pwm_in,
   output logic [15:0] hi_len_out [6],
   output logic [15:0] period_out [6],
   output logic [15:0] rises_out [6]
);
   logic [5:0] last;
   logic [15:0] run [6];
   logic [15:0] since [6];
   // ---------------------------------------------
   // Width and period measurement
   // ---------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      last <= resetn_in ? pwm_in : 6'h00;
      for (int i = 0; i < 6; i++) begin
         if (!resetn_in) begin
            run[i] <= 16'h0000;
            since[i] <= 16'h0000;
            hi_len_out[i] <= 16'h0000;
            period_out[i] <= 16'h0000;
            rises_out[i] <= 16'h0000;
         end else begin
            run[i] <= pwm_in[i] ? run[i] + 16'h0001 : 16'h0000;
            if (!pwm_in[i] && last[i]) begin
               hi_len_out[i] <= run[i];
            end
            if (pwm_in[i] && !last[i]) begin
               period_out[i] <= since[i];
               since[i] <= 16'h0001;
               rises_out[i] <= rises_out[i] + 16'h0001;
            end else begin
               since[i] <= since[i] + 16'h0001;
            end
         end
      end
   end
endmodule

// File: dv/multi_output_pwm_timer_tb_top.sv
// Self-checking bench for the PWM timer
`timescale 1ns/100ps
`include "mpt_regs.svh"
module multi_output_pwm_timer_tb_top;
   logic sys_clk;
   logic resetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [1:0] cap;
   logic [5:0] pwm;
   logic irq;
   logic [15:0] hi_len [6];
   logic [15:0] period [6];
   logic [15:0] rises [6];
   logic [31:0] d;
   int errors;
   int checks_done;

   mpt_pwm_timer dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
      .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp), .cap_in(cap), .pwm_out(pwm),
      .irq_out(irq));
   mpt_load_model load (.sys_clk_in(sys_clk), .resetn_in(resetn), .pwm_in(pwm), .hi_len_out(hi_len),
      .period_out(period), .rises_out(rises));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task wait_ready;
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            chk("hready", 32'h1, {31'h0, hreadyout});
            wrap_up;
         end
         @(posedge sys_clk);
      end
   endtask

   task bus_write(input logic [7:0] a, input logic [31:0] w);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w;
      wait_ready;
   endtask

   task bus_read(input logic [7:0] a);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'b00;
      wait_ready;
      d = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_reset;
      bus_read(`MPT_OFF_CTRL);
      chk("ctrl", `MPT_RST_WORD, d);
      bus_read(8'h80);
      chk("unmapped", 32'h0, d);
      chk("pwm", 32'h0, {26'h0, pwm});
      bus_write(`MPT_OFF_MR0 + 8'h04, 32'hdead_beef);
      bus_read(`MPT_OFF_MR0 + 8'h04);
      chk("mr1", 32'hdead_beef, d);
      $display("t_reset done");
   endtask

   task t_stop_irq;
      int n;
      bus_write(`MPT_OFF_PLIM, 32'h1);
      bus_write(`MPT_OFF_MR0, 32'h5);
      bus_write(`MPT_OFF_MCTL, 32'h5);
      bus_write(`MPT_OFF_MASK, 32'h1);
      bus_write(`MPT_OFF_CTRL, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, irq});
      if (n >= 200) begin
         wrap_up;
      end
      chk("prescale", 32'h1, {31'h0, n >= 10});
      bus_read(`MPT_OFF_COUNT);
      chk("count_stop", 32'h6, d);
      bus_read(`MPT_OFF_CTRL);
      chk("ctrl_en", 32'h0, d & 32'h1);
      bus_write(`MPT_OFF_MASK, 32'h0);
      cyc(1);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus_read(`MPT_OFF_STAT);
      chk("stat", 32'h1, d);
      bus_write(`MPT_OFF_STAT, 32'h1);
      bus_read(`MPT_OFF_STAT);
      chk("stat_clr", 32'h0, d);
      bus_read(`MPT_OFF_COUNT);
      chk("count_held", 32'h6, d);
      $display("t_stop_irq done");
   endtask

   task t_counter;
      logic [31:0] src [4];
      logic [31:0] want [4];
      // Rise on cap 0, rise on cap 1, fall on cap 0, both edges on cap 1
      src = '{32'h1, 32'h5, 32'h2, 32'h7};
      want = '{32'h3, 32'h6, 32'h9, 32'hf};
      bus_write(`MPT_OFF_MCTL, 32'h0);
      bus_write(`MPT_OFF_CTRL, 32'h2);
      bus_write(`MPT_OFF_PLIM, 32'h0);
      for (int s = 0; s < 4; s++) begin
         bus_write(`MPT_OFF_CSRC, src[s]);
         bus_write(`MPT_OFF_CTRL, 32'h1);
         for (int i = 0; i < 3; i++) begin
            cap <= 2'b01;
            cyc(3);
            cap <= 2'b10;
            cyc(3);
            cap <= 2'b00;
            cyc(3);
         end
         bus_read(`MPT_OFF_COUNT);
         chk("count_edges", want[s], d);
      end
      $display("t_counter done");
   endtask

   task t_pwm;
      bus_write(`MPT_OFF_CTRL, 32'h2);
      bus_write(`MPT_OFF_CSRC, 32'h0);
      bus_write(`MPT_OFF_MCTL, 32'h2);
      bus_write(`MPT_OFF_MR0, 32'h9);
      bus_write(`MPT_OFF_MR0 + 8'h04, 32'h3);
      bus_write(`MPT_OFF_MR0 + 8'h08, 32'h7);
      bus_write(`MPT_OFF_OCFG, 32'h302);
      bus_write(`MPT_OFF_LATCH, 32'h7);
      bus_write(`MPT_OFF_CTRL, 32'h9);
      cyc(40);
      chk("period1", 32'ha, {16'h0, period[0]});
      chk("width1", 32'h4, {16'h0, hi_len[0]});
      chk("period2", 32'ha, {16'h0, period[1]});
      chk("width2", 32'h4, {16'h0, hi_len[1]});
      chk("out3_low", 32'h0, {16'h0, rises[2]});
      bus_write(`MPT_OFF_MR0 + 8'h04, 32'h5);
      cyc(30);
      chk("width1_held", 32'h4, {16'h0, hi_len[0]});
      bus_write(`MPT_OFF_LATCH, 32'h2);
      cyc(30);
      chk("width1_new", 32'h6, {16'h0, hi_len[0]});
      chk("width2_new", 32'h2, {16'h0, hi_len[1]});
      bus_write(`MPT_OFF_MR0 + 8'h04, 32'h8);
      bus_write(`MPT_OFF_MR0 + 8'h08, 32'h2);
      bus_write(`MPT_OFF_LATCH, 32'h6);
      cyc(30);
      chk("width2_neg", 32'h4, {16'h0, hi_len[1]});
      chk("width1_long", 32'h9, {16'h0, hi_len[0]});
      bus_write(`MPT_OFF_CTRL, 32'h1);
      cyc(2);
      chk("pwm_off", 32'h0, {26'h0, pwm});
      $display("t_pwm done");
   endtask

   // ---------------------------------------------
   // Clock, reset and main sequence
   // ---------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      cap = 2'b00;
      errors = 0;
      checks_done = 0;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_stop_irq;
      t_counter;
      t_pwm;
      wrap_up;
   end
endmodule
